/* File: src/ssd_pkg.sv */
// Purpose: Shared constants for the safety sensor diagnostic byte block
// Assumes: One 250 MHz clock, synchronous active-high reset
// Notes: Bit positions follow the request, response and diagnostic byte maps
// Behaviour
// - Sensor returns one status byte per cycle
// - Diagnostic byte carries warnings or error flags
// - All flags are active high
// - Bit0 outputs on, bit1 actuator detected
// - Bit4 both inputs energised, bits2-3 zero
// - Bit5 actuator in limit area
// - Bit6 warning pending, bit7 enabling path off
// - Error byte bits 0-5 fault causes
// - Warning bits 0-3, 5 internal, 6 comms
// - Idle with inputs energised reports only bit4
// - Fault: outputs off, bits 7,6,4,1 set
// - Error clears: cause gone plus reset fall or guard open
// - Persisting warning in bits 0-3 or 5 turns outputs off after 30 minutes; a comms warning never times out
// - Communication loss holds the safety outputs unless an error is latched
package ssd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte geometry
  localparam int SSD_BYTE_W = 8;
  localparam int SSD_CAUSE_W = 6;
  localparam logic [7:0] SSD_BYTE_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Request byte
  localparam int SSD_REQ_ERR_RESET_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Response byte
  localparam int SSD_RSP_OUTPUTS_ON_BIT = 0;
  localparam int SSD_RSP_ACTUATOR_BIT = 1;
  localparam int SSD_RSP_INPUTS_BIT = 4;
  localparam int SSD_RSP_LIMIT_BIT = 5;
  localparam int SSD_RSP_WARNING_BIT = 6;
  localparam int SSD_RSP_ERROR_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic bytes, cause positions shared by warning and error bytes
  localparam int SSD_CAUSE_OUT_A_BIT = 0;
  localparam int SSD_CAUSE_OUT_B_BIT = 1;
  localparam int SSD_CAUSE_CROSS_BIT = 2;
  localparam int SSD_CAUSE_TEMP_BIT = 3;
  localparam int SSD_CAUSE_ACTUATOR_BIT = 4;
  localparam int SSD_CAUSE_INTERNAL_BIT = 5;
  localparam int SSD_WARN_COMM_BIT = 6;
  localparam logic [5:0] SSD_WARN_CAUSE_MASK = 6'h2F;
  localparam logic [5:0] SSD_ERR_CAUSE_MASK = 6'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint unsigned SSD_CLK_HZ = 64'h0000_0000_0EE6_B280;
  localparam longint unsigned SSD_WARN_TIME_MIN = 64'h0000_0000_0000_001E;
  localparam longint unsigned SSD_SEC_PER_MIN = 64'h0000_0000_0000_003C;
  localparam longint unsigned SSD_WARN_CYCLES =
    SSD_WARN_TIME_MIN * SSD_SEC_PER_MIN * SSD_CLK_HZ;
  localparam int SSD_WARN_CNT_W = 40;

endpackage

/* File: src/ssd_persist_timer.sv */
// Purpose: Counts how long a condition has persisted without a break
// Assumes: Condition is synchronous to the clock
// Notes: Expiry is a level held until the condition drops
`timescale 1ns/1ps
module ssd_persist_timer
  import ssd_pkg::*;
#(
  parameter int CNT_W = SSD_WARN_CNT_W,
  parameter longint unsigned LIMIT = SSD_WARN_CYCLES
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Condition
  input wire logic i_active,
  // Result
  output logic o_expired
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic expired_reg;
  logic expired_next;
  wire logic at_limit;

  // Saturating at the limit keeps a very long fault from wrapping around
  assign at_limit = (count_reg >= CNT_W'(LIMIT - 1));
  assign count_next = !i_active ? '0 : (at_limit ? count_reg : count_reg + 1'b1);
  assign expired_next = i_active & at_limit;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign o_expired = expired_reg & i_active;

endmodule

/* File: src/ssd_diag_bytes.sv */
// Purpose: Safety sensor status, warning and error byte engine
// Assumes: Sensor condition inputs are already debounced and synchronous
// Notes: Byte serialisation on the chain is done outside this block
`timescale 1ns/1ps
module ssd_diag_bytes
  import ssd_pkg::*;
#(
  parameter longint unsigned WARN_CYCLES = SSD_WARN_CYCLES,
  parameter int WARN_CNT_W = SSD_WARN_CNT_W
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Request byte from the gateway
  input wire logic [7:0] i_request_byte,
  input wire logic i_request_valid,
  // Sensing front end
  input wire logic i_actuator_in_range,
  input wire logic i_actuator_in_limit,
  input wire logic i_safety_in_a,
  input wire logic i_safety_in_b,
  // Fault and warning causes, same bit positions as the diagnostic bytes
  input wire logic [5:0] i_fault_cause,
  input wire logic [5:0] i_warn_cause,
  input wire logic i_comm_fault,
  // Snapshot request from the chain framer
  input wire logic i_snapshot_req,
  // Safety outputs
  output logic o_safety_out_a,
  output logic o_safety_out_b,
  // Transmitted bytes
  output logic [7:0] o_status_response_byte,
  output logic [7:0] o_warning_flag_byte,
  output logic [7:0] o_error_flag_byte,
  output logic [7:0] o_diag_byte,
  output logic o_diag_is_error,
  output logic o_snapshot_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte packing helpers

  function automatic logic [7:0] pack_response(
    input logic outputs_on,
    input logic actuated,
    input logic inputs_ok,
    input logic in_limit,
    input logic warn_pend,
    input logic err_latched
  );
    logic [7:0] b;
    b = SSD_BYTE_RESET;
    b[SSD_RSP_OUTPUTS_ON_BIT] = outputs_on;
    b[SSD_RSP_ACTUATOR_BIT] = actuated;
    b[SSD_RSP_INPUTS_BIT] = inputs_ok;
    b[SSD_RSP_LIMIT_BIT] = in_limit;
    b[SSD_RSP_WARNING_BIT] = warn_pend | err_latched;
    b[SSD_RSP_ERROR_BIT] = err_latched;
    return b;
  endfunction

  function automatic logic [7:0] pack_causes(
    input logic [5:0] causes,
    input logic [5:0] mask,
    input logic comm
  );
    logic [7:0] b;
    b = SSD_BYTE_RESET;
    b[5:0] = causes & mask;
    b[SSD_WARN_COMM_BIT] = comm;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request byte capture

  logic [7:0] request_reg;
  logic [7:0] request_next;
  logic req_bit7_reg;
  logic req_bit7_next;
  wire logic reset_fall;

  assign request_next = i_request_valid ? i_request_byte : request_reg;
  // Bits 0 to 6 of the request carry nothing and are ignored
  assign req_bit7_next = i_request_valid ? i_request_byte[SSD_REQ_ERR_RESET_BIT]
                                         : req_bit7_reg;
  // Reset acts on the 1 to 0 change, so a stuck-high bit cannot keep clearing
  assign reset_fall = i_request_valid & req_bit7_reg
                      & ~i_request_byte[SSD_REQ_ERR_RESET_BIT];

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      request_reg <= SSD_BYTE_RESET;
      req_bit7_reg <= 1'b0;
    end else begin
      request_reg <= request_next;
      req_bit7_reg <= req_bit7_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Guard opening detection

  logic actuated_prev_reg;
  wire logic guard_opened;

  assign guard_opened = actuated_prev_reg & ~i_actuator_in_range;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      actuated_prev_reg <= 1'b0;
    end else begin
      actuated_prev_reg <= i_actuator_in_range;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Warning persistence

  wire logic [5:0] warn_live;
  wire logic warn_cause_any;
  wire logic warn_expired;
  wire logic warn_pending;

  assign warn_live = i_warn_cause & SSD_WARN_CAUSE_MASK;
  assign warn_cause_any = |warn_live;
  assign warn_pending = warn_cause_any | i_comm_fault;

  ssd_persist_timer #(
    .CNT_W(WARN_CNT_W),
    .LIMIT(WARN_CYCLES)
  ) u_warn_timer (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_active(warn_cause_any),
    .o_expired(warn_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Latched error flags

  logic [5:0] err_reg;
  logic [5:0] err_next;
  wire logic [5:0] err_set;
  wire logic [5:0] err_cause_now;
  wire logic err_clear_ok;
  wire logic err_any;

  // A warning that outlives the timer becomes an error of the same kind
  assign err_set = (i_fault_cause & SSD_ERR_CAUSE_MASK)
                   | (warn_expired ? warn_live : 6'h00);
  assign err_cause_now = (i_fault_cause & SSD_ERR_CAUSE_MASK) | warn_live;
  assign err_clear_ok = reset_fall | guard_opened;
  assign err_any = |err_reg;

  genvar gi;
  generate
    for (gi = 0; gi < SSD_CAUSE_W; gi++) begin : g_err_bit
      // Set wins over clear; clear also needs the cause to be gone
      assign err_next[gi] = err_set[gi] ? 1'b1
                          : ((err_clear_ok & ~err_cause_now[gi]) ? 1'b0
                                                                 : err_reg[gi]);
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      err_reg <= 6'h00;
    end else begin
      err_reg <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Safety output drive

  logic outputs_on_reg;
  logic outputs_on_next;
  wire logic inputs_ok;
  wire logic enable_cond;

  assign inputs_ok = i_safety_in_a & i_safety_in_b;
  // Outputs only turn on when actuated, inputs energised and no latched error
  assign enable_cond = i_actuator_in_range & inputs_ok & ~err_any;
  // Error forces off even during a link loss; safety beats hold
  assign outputs_on_next = err_any ? 1'b0
                         : (i_comm_fault ? outputs_on_reg : enable_cond);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      outputs_on_reg <= 1'b0;
    end else begin
      outputs_on_reg <= outputs_on_next;
    end
  end

  assign o_safety_out_a = outputs_on_reg;
  assign o_safety_out_b = outputs_on_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly

  wire logic [7:0] status_now;
  wire logic [7:0] warning_now;
  wire logic [7:0] error_now;
  wire logic [7:0] diag_now;

  assign status_now = pack_response(outputs_on_reg, i_actuator_in_range, inputs_ok,
                                    i_actuator_in_limit & i_actuator_in_range,
                                    warn_pending, err_any);
  assign warning_now = pack_causes(warn_live, SSD_WARN_CAUSE_MASK, i_comm_fault);
  assign error_now = pack_causes(err_reg, SSD_ERR_CAUSE_MASK, 1'b0);
  // Errors take the single diagnostic slot ahead of warnings
  assign diag_now = err_any ? error_now : warning_now;

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot registers

  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] warning_reg;
  logic [7:0] warning_next;
  logic [7:0] error_byte_reg;
  logic [7:0] error_byte_next;
  logic [7:0] diag_reg;
  logic [7:0] diag_next;
  logic diag_is_error_reg;
  logic diag_is_error_next;
  logic snap_valid_reg;

  // All bytes load on the same edge so no frame mixes two states
  assign status_next = i_snapshot_req ? status_now : status_reg;
  assign warning_next = i_snapshot_req ? warning_now : warning_reg;
  assign error_byte_next = i_snapshot_req ? error_now : error_byte_reg;
  assign diag_next = i_snapshot_req ? diag_now : diag_reg;
  assign diag_is_error_next = i_snapshot_req ? err_any : diag_is_error_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      status_reg <= SSD_BYTE_RESET;
      warning_reg <= SSD_BYTE_RESET;
      error_byte_reg <= SSD_BYTE_RESET;
      diag_reg <= SSD_BYTE_RESET;
      diag_is_error_reg <= 1'b0;
      snap_valid_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      warning_reg <= warning_next;
      error_byte_reg <= error_byte_next;
      diag_reg <= diag_next;
      diag_is_error_reg <= diag_is_error_next;
      snap_valid_reg <= i_snapshot_req;
    end
  end

  assign o_status_response_byte = status_reg;
  assign o_warning_flag_byte = warning_reg;
  assign o_error_flag_byte = error_byte_reg;
  assign o_diag_byte = diag_reg;
  assign o_diag_is_error = diag_is_error_reg;
  assign o_snapshot_valid = snap_valid_reg;

endmodule

/* File: verification/ssd_gw_model.sv */
// Purpose: Gateway stand-in that delivers request bytes to the sensor
// Assumes: Called at a falling edge of the clock
// Notes: Released byte lines show the inverse of the last value
`timescale 1ns/1ps
module ssd_gw_model (
  // Clock
  input wire logic i_sys_clk,
  // Request byte toward the sensor
  output logic [7:0] o_request_byte,
  output logic o_request_valid
);
  initial begin
    o_request_byte = 8'h00;
    o_request_valid = 1'b0;
  end
  // One byte a call, only toward the sensor, bit 7 asks error reset
  task automatic send(input logic [7:0] b);
    o_request_byte = b;
    o_request_valid = 1'b1;
    @(negedge i_sys_clk);
    o_request_valid = 1'b0;
    o_request_byte = ~b;
    @(negedge i_sys_clk);
  endtask
endmodule

/* File: verification/ssd_diag_bytes_chk.sv */
// Purpose: Port checker for the diagnostic byte engine
// Assumes: Single clock, synchronous active-high reset
// Notes: Fault sequences need the cause held into the snapshot cycle
`timescale 1ns/1ps
module ssd_diag_bytes_chk (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Watched inputs
  input wire logic i_actuator_in_range,
  input wire logic i_safety_in_a,
  input wire logic i_safety_in_b,
  input wire logic [5:0] i_fault_cause,
  input wire logic i_comm_fault,
  input wire logic i_snapshot_req,
  // Watched outputs
  input wire logic o_safety_out_a,
  input wire logic o_safety_out_b,
  input wire logic [7:0] o_status_response_byte,
  input wire logic [7:0] o_warning_flag_byte,
  input wire logic [7:0] o_error_flag_byte,
  input wire logic o_diag_is_error,
  input wire logic o_snapshot_valid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_fault;
    i_fault_cause[0] ##1 (i_fault_cause[0] && i_snapshot_req);
  endsequence
  property p_valid; i_snapshot_req |=> o_snapshot_valid; endproperty
  property p_no_valid; !i_snapshot_req |=> !o_snapshot_valid; endproperty
  property p_pair; o_safety_out_a == o_safety_out_b; endproperty
  property p_bit0;
    i_snapshot_req |=> o_status_response_byte[0] == $past(o_safety_out_a);
  endproperty
  property p_bit14;
    i_snapshot_req |=> o_status_response_byte[1] == $past(i_actuator_in_range)
      && o_status_response_byte[4] == ($past(i_safety_in_a) & $past(i_safety_in_b));
  endproperty
  property p_unused;
    i_snapshot_req |=> o_status_response_byte[3:2] == 2'b00
      && o_error_flag_byte[7:6] == 2'b00 && !o_warning_flag_byte[4] && !o_warning_flag_byte[7];
  endproperty
  property p_comm; i_snapshot_req |=> o_warning_flag_byte[6] == $past(i_comm_fault); endproperty
  property p_fault_off; |i_fault_cause |=> ##1 !o_safety_out_a; endproperty
  property p_fault_bytes;
    s_fault |=> o_error_flag_byte[0] && o_status_response_byte[7:6] == 2'b11 && o_diag_is_error;
  endproperty
  property p_hold_off; i_comm_fault && !o_safety_out_a |=> !o_safety_out_a; endproperty
  a_valid: assert property (p_valid) else $error("snapshot valid missing");
  a_no_valid: assert property (p_no_valid) else $error("stray snapshot valid");
  a_pair: assert property (p_pair) else $error("safety outputs differ");
  a_bit0: assert property (p_bit0) else $error("status bit 0 wrong");
  a_bit14: assert property (p_bit14) else $error("status bit 1 or 4 wrong");
  a_unused: assert property (p_unused) else $error("unused bit set");
  a_comm: assert property (p_comm) else $error("comm warning bit wrong");
  a_fault_off: assert property (p_fault_off) else $error("outputs on after fault");
  a_fault_bytes: assert property (p_fault_bytes) else $error("fault bytes wrong");
  a_hold_off: assert property (p_hold_off) else $error("outputs left hold");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ssd_diag_bytes ssd_diag_bytes_chk u_ssd_diag_bytes_chk (.i_sys_clk, .i_reset,
  .i_actuator_in_range, .i_safety_in_a, .i_safety_in_b, .i_fault_cause, .i_comm_fault,
  .i_snapshot_req, .o_safety_out_a, .o_safety_out_b, .o_status_response_byte,
  .o_warning_flag_byte, .o_error_flag_byte, .o_diag_is_error, .o_snapshot_valid);

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the diagnostic byte engine
// Assumes: Warning timer shortened to 16 cycles
// Notes: Inputs change on the falling edge only
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  typedef struct packed {logic [3:0] c; logic [5:0] w; logic m; logic [7:0] s; logic [7:0] b;}
    ssd_row_t;
  logic i_sys_clk, i_reset, i_request_valid, i_actuator_in_range, i_actuator_in_limit;
  logic i_safety_in_a, i_safety_in_b, i_comm_fault, i_snapshot_req, o_safety_out_a;
  logic o_diag_is_error, o_snapshot_valid, o_safety_out_b;
  logic [7:0] i_request_byte, o_status_response_byte, o_warning_flag_byte;
  logic [7:0] o_error_flag_byte, o_diag_byte;
  logic [5:0] i_fault_cause, i_warn_cause;
  int n_fail = 0;
  int n_compared = 0;
  // Range, limit, input a, input b; warn causes; comm; status; warning
  ssd_row_t rows[8] = '{'{4'h3, 6'h00, 1'b0, 8'h10, 8'h00}, '{4'hB, 6'h00, 1'b0, 8'h13, 8'h00},
    '{4'hF, 6'h00, 1'b0, 8'h33, 8'h00}, '{4'hB, 6'h01, 1'b0, 8'h53, 8'h01},
    '{4'hB, 6'h3F, 1'b0, 8'h53, 8'h2F}, '{4'hB, 6'h00, 1'b1, 8'h53, 8'h40},
    '{4'h9, 6'h00, 1'b0, 8'h02, 8'h00}, '{4'h7, 6'h00, 1'b0, 8'h10, 8'h00}};
  ssd_gw_model u_ssd_gw_model (.i_sys_clk(i_sys_clk), .o_request_byte(i_request_byte),
    .o_request_valid(i_request_valid));
  ssd_diag_bytes #(.WARN_CYCLES(16)) u_ssd_diag_bytes (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_request_byte(i_request_byte), .i_request_valid(i_request_valid),
    .i_actuator_in_range(i_actuator_in_range), .i_actuator_in_limit(i_actuator_in_limit),
    .i_safety_in_a(i_safety_in_a), .i_safety_in_b(i_safety_in_b),
    .i_fault_cause(i_fault_cause), .i_warn_cause(i_warn_cause), .i_comm_fault(i_comm_fault),
    .i_snapshot_req(i_snapshot_req), .o_safety_out_a(o_safety_out_a),
    .o_safety_out_b(o_safety_out_b),
    .o_status_response_byte(o_status_response_byte), .o_warning_flag_byte(o_warning_flag_byte),
    .o_error_flag_byte(o_error_flag_byte), .o_diag_byte(o_diag_byte),
    .o_diag_is_error(o_diag_is_error), .o_snapshot_valid(o_snapshot_valid));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic snap();
    i_snapshot_req = 1'b1;
    idle(1);
    i_snapshot_req = 1'b0;
    `CHK(o_snapshot_valid, 1'b1)
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Bounded run, so a hang still ends in a verdict
  initial begin
    repeat (4000) @(posedge i_sys_clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    {i_reset, i_actuator_in_range, i_actuator_in_limit, i_safety_in_a} = 4'h8;
    {i_safety_in_b, i_comm_fault, i_snapshot_req, i_fault_cause, i_warn_cause} = 15'h0;
    idle(5);
    i_reset = 1'b0;
    `CHK(o_status_response_byte, 8'h00)
    foreach (rows[k]) begin
      {i_actuator_in_range, i_actuator_in_limit, i_safety_in_a, i_safety_in_b} = rows[k].c;
      {i_warn_cause, i_comm_fault} = {rows[k].w, rows[k].m};
      idle(2);
      snap();
      `CHK(o_status_response_byte, rows[k].s)
      `CHK(o_warning_flag_byte, rows[k].b)
      `CHK(o_diag_byte, rows[k].b)
    end
    // Latched fault survives a reset request while its cause stays
    {i_actuator_in_range, i_actuator_in_limit} = 2'b10;
    idle(3);
    i_fault_cause = 6'h3F;
    idle(2);
    snap();
    `CHK(o_status_response_byte, 8'hD2)
    `CHK(o_diag_byte, 8'h3F)
    `CHK(o_diag_is_error, 1'b1)
    u_ssd_gw_model.send(8'h80);
    u_ssd_gw_model.send(8'h00);
    snap();
    `CHK(o_error_flag_byte, 8'h3F)
    i_fault_cause = 6'h00;
    u_ssd_gw_model.send(8'h80);
    u_ssd_gw_model.send(8'h7F);
    idle(2);
    snap();
    `CHK(o_status_response_byte, 8'h13)
    `CHK(o_diag_is_error, 1'b0)
    // Guard opening also clears
    i_fault_cause = 6'h10;
    idle(1);
    i_fault_cause = 6'h00;
    idle(2);
    i_actuator_in_range = 1'b0;
    idle(3);
    snap();
    `CHK(o_error_flag_byte, 8'h00)
    // Persisting warning turns outputs off after the timer
    i_actuator_in_range = 1'b1;
    idle(3);
    i_warn_cause = 6'h08;
    idle(8);
    `CHK(o_safety_out_a, 1'b1)
    idle(12);
    snap();
    `CHK(o_error_flag_byte, 8'h08)
    `CHK(o_status_response_byte, 8'hD2)
    i_warn_cause = 6'h00;
    u_ssd_gw_model.send(8'h80);
    u_ssd_gw_model.send(8'h00);
    idle(3);
    // Link loss freezes both on and off states
    i_comm_fault = 1'b1;
    i_actuator_in_range = 1'b0;
    idle(3);
    `CHK(o_safety_out_a, 1'b1)
    i_comm_fault = 1'b0;
    idle(2);
    i_comm_fault = 1'b1;
    i_actuator_in_range = 1'b1;
    idle(3);
    `CHK(o_safety_out_a, 1'b0)
    i_comm_fault = 1'b0;
    idle(2);
    `CHK(o_safety_out_b, o_safety_out_a)
    // Mid-run reset clears outputs and bytes, then normal drive returns
    i_reset = 1'b1;
    idle(2);
    i_reset = 1'b0;
    `CHK(o_safety_out_b, 1'b0)
    `CHK(o_status_response_byte, 8'h00)
    `CHK(o_snapshot_valid, 1'b0)
    idle(2);
    `CHK(o_safety_out_b, 1'b1)
    snap();
    `CHK(o_status_response_byte, 8'h13)
    wrap_up();
  end
endmodule
